// ==== verilog/timer_consts.vh ====
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// ****************************************
// Register indices and byte addresses
// ****************************************
// Printed offsets are not word aligned, so each index is scaled by four
`define IDX_CTRL0      18'h0FF30
`define IDX_CTRL1      18'h0FF31
`define IDX_RELOAD0    18'h0FF32
`define IDX_RELOAD1    18'h0FF33
`define IDX_COMPARE0   18'h0FF34
`define IDX_COMPARE1   18'h0FF35
`define IDX_COUNT0     18'h0FF36
`define IDX_COUNT1     18'h0FF37
`define IDX_EVENTS     18'h0FF38
`define ADDR_W         20

// ****************************************
// Control register fields
// ****************************************
`define BIT_WIDTH_SEL  7
`define BIT_OUT_EN     3
`define BIT_RUN        2
`define BIT_PRESET     1
`define BIT_CLK_SRC    0

// ****************************************
// Event register fields
// ****************************************
`define BIT_EV_UF0     0
`define BIT_EV_CM0     1
`define BIT_EV_UF1     2
`define BIT_EV_CM1     3

// ****************************************
// Reset values
// ****************************************
`define RST_CTRL       8'h00
`define RST_RELOAD     8'hFF
`define RST_COMPARE    8'h00

// ****************************************
// Bus answers
// ****************************************
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ==== verilog/dual_mode_reload_down_timer.v ====
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "timer_consts.vh"

module dual_mode_reload_down_timer (
  input wire clock,
  input wire rst_n,
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ch0_prescaler_clock,
  input wire ch1_prescaler_clock,
  input wire ch0_event_clock,
  input wire ch1_event_clock,
  output reg [1:0] timer_wave_out
);

  // ****************************************
  // Address decoding helper
  // ****************************************
  // Word index from byte address, upper bits must match the index width
  function is_reg;
    input [`ADDR_W-1:0] addr;
    input [17:0] idx;
    begin
      is_reg = (addr[`ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
    end
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  reg width_select_r, ch0_output_enable_r, ch1_output_enable_r;
  reg ch0_run_r, ch1_run_r, ch0_clock_source_r, ch1_clock_source_r;
  reg [7:0] ch0_reload_value_r, ch1_reload_value_r;
  reg [7:0] ch0_compare_value_r, ch1_compare_value_r;
  reg [7:0] cnt0_r, cnt1_r, cnt0_nxt, cnt1_nxt;
  reg [3:0] events_r, events_nxt;
  reg clk0_prev_r, clk1_prev_r, eq0_prev_r, eq1_prev_r;
  reg [1:0] uf_seen_r, wave_r;
  // Bus side state
  reg aw_full_r, w_full_r, w_lane0_r, rhit_nxt;
  reg [`ADDR_W-1:0] aw_addr_r;
  reg [7:0] w_data_r;
  reg [31:0] rdata_nxt;
  wire do_write, wr_ctrl0, wr_ctrl1, wr_events, wr_hit;
  wire preset0, preset1, run0_eff, run1_eff, src0, src1;
  wire edge0, edge1, tick0, tick1, uf0_ev, uf1_ev;
  wire eq0, eq1, cm0_ev, cm1_ev;
  wire [1:0] fixed_high, uf_pulse, cm_pulse;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data latch separately, so either order is accepted
  assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_r & ~s_axi_bvalid;
  assign do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
  // Mapped indices are contiguous, so one range test covers them
  assign wr_hit = (aw_addr_r[`ADDR_W-1:2] >= `IDX_CTRL0) &&
                  (aw_addr_r[`ADDR_W-1:2] <= `IDX_EVENTS) &&
                  (aw_addr_r[1:0] == 2'h0);

  // Only lane 0 carries data; the other lanes are ignored
  assign wr_ctrl0 = do_write & w_lane0_r & is_reg(aw_addr_r, `IDX_CTRL0);
  assign wr_ctrl1 = do_write & w_lane0_r & is_reg(aw_addr_r, `IDX_CTRL1);
  assign wr_events = do_write & w_lane0_r & is_reg(aw_addr_r, `IDX_EVENTS);

  // Write handshake and response
  always @(posedge clock) begin
    if (!rst_n) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= {`ADDR_W{1'b0}};
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Reset values of reload and compare
  always @(posedge clock) begin
    if (!rst_n) begin
      width_select_r <= 1'b0;
      ch0_output_enable_r <= 1'b0;
      ch1_output_enable_r <= 1'b0;
      ch0_run_r <= 1'b0;
      ch1_run_r <= 1'b0;
      ch0_clock_source_r <= 1'b0;
      ch1_clock_source_r <= 1'b0;
      ch0_reload_value_r <= `RST_RELOAD;
      ch1_reload_value_r <= `RST_RELOAD;
      ch0_compare_value_r <= `RST_COMPARE;
      ch1_compare_value_r <= `RST_COMPARE;
    end else if (do_write && w_lane0_r) begin
      if (is_reg(aw_addr_r, `IDX_CTRL0)) begin
        width_select_r <= w_data_r[`BIT_WIDTH_SEL];
        ch0_output_enable_r <= w_data_r[`BIT_OUT_EN];
        ch0_run_r <= w_data_r[`BIT_RUN];
        ch0_clock_source_r <= w_data_r[`BIT_CLK_SRC];
      end else if (is_reg(aw_addr_r, `IDX_CTRL1)) begin
        ch1_output_enable_r <= w_data_r[`BIT_OUT_EN];
        ch1_run_r <= w_data_r[`BIT_RUN];
        ch1_clock_source_r <= w_data_r[`BIT_CLK_SRC];
      end else if (is_reg(aw_addr_r, `IDX_RELOAD0)) begin
        ch0_reload_value_r <= w_data_r;
      end else if (is_reg(aw_addr_r, `IDX_RELOAD1)) begin
        ch1_reload_value_r <= w_data_r;
      end else if (is_reg(aw_addr_r, `IDX_COMPARE0)) begin
        ch0_compare_value_r <= w_data_r;
      end else if (is_reg(aw_addr_r, `IDX_COMPARE1)) begin
        ch1_compare_value_r <= w_data_r;
      end
    end
  end

  // ****************************************
  // Effective controls per mode
  // ****************************************
  // Cascade: channel 1 run and source are masked off but read back as written; its preset follows channel 0
  assign run0_eff = ch0_run_r;
  assign run1_eff = ch1_run_r & ~width_select_r;
  assign preset0 = wr_ctrl0 & w_data_r[`BIT_PRESET];
  // Cascade preset of channel 0 loads all 16 bits
  assign preset1 = width_select_r ? preset0 :
                   (wr_ctrl1 & w_data_r[`BIT_PRESET]);
  // Prescaler or event input, taken as is
  assign src0 = ch0_clock_source_r ? ch0_event_clock : ch0_prescaler_clock;
  assign src1 = (ch1_clock_source_r & ~width_select_r) ?
                ch1_event_clock : ch1_prescaler_clock;

  // Count on the rising edge of the selected source
  always @(posedge clock) begin
    if (!rst_n) begin
      clk0_prev_r <= 1'b0;
      clk1_prev_r <= 1'b0;
    end else begin
      clk0_prev_r <= src0;
      clk1_prev_r <= src1;
    end
  end
  assign edge0 = src0 & ~clk0_prev_r;
  assign edge1 = src1 & ~clk1_prev_r;

  // Run gates the count clock; cascade uses channel 0 run
  assign tick0 = run0_eff & edge0;
  // Cascade: channel 1 steps once per channel 0 underflow
  assign tick1 = width_select_r ? (tick0 & (cnt0_r == 8'h00)) :
                 (run1_eff & edge1);
  // Underflow is a tick while the counter holds zero
  assign uf0_ev = tick0 & (cnt0_r == 8'h00);
  assign uf1_ev = tick1 & (cnt1_r == 8'h00);

  // ****************************************
  // Down counters
  // ****************************************
  // Preset wins over a count in the same cycle
  always @* begin
    cnt0_nxt = cnt0_r;
    cnt1_nxt = cnt1_r;
    if (preset0) begin
      cnt0_nxt = ch0_reload_value_r;
    end else if (tick0) begin
      if (cnt0_r != 8'h00) begin
        cnt0_nxt = cnt0_r - 8'h01;
      end else if (width_select_r && (cnt1_r != 8'h00)) begin
        // Borrow into the high byte, low byte wraps
        cnt0_nxt = 8'hFF;
      end else begin
        // Underflow reloads from the reload register
        cnt0_nxt = ch0_reload_value_r;
      end
    end
    if (preset1) begin
      cnt1_nxt = ch1_reload_value_r;
    end else if (tick1) begin
      if (cnt1_r != 8'h00) begin
        cnt1_nxt = cnt1_r - 8'h01;
      end else begin
        // Channel 1 reload, the high byte of the 16-bit reload in cascade
        cnt1_nxt = ch1_reload_value_r;
      end
    end
  end

  // Counters hold while stopped; events never pause them
  always @(posedge clock) begin
    if (!rst_n) begin
      cnt0_r <= 8'h00;
      cnt1_r <= 8'h00;
    end else begin
      cnt0_r <= cnt0_nxt;
      cnt1_r <= cnt1_nxt;
    end
  end

  // ****************************************
  // Compare match detection
  // ****************************************
  // Equality, 16 bits wide in cascade
  assign eq0 = (cnt0_r == ch0_compare_value_r);
  assign eq1 = width_select_r ?
               ({cnt1_r, cnt0_r} ==
                {ch1_compare_value_r, ch0_compare_value_r}) :
               (cnt1_r == ch1_compare_value_r);

  // One event per arrival at the compare value, not per cycle held
  always @(posedge clock) begin
    if (!rst_n) begin
      eq0_prev_r <= 1'b1; // Count and compare both reset to zero
      eq1_prev_r <= 1'b1; // so no false match right after reset
    end else begin
      eq0_prev_r <= eq0;
      eq1_prev_r <= eq1;
    end
  end
  assign cm0_ev = eq0 & ~eq0_prev_r;
  assign cm1_ev = eq1 & ~eq1_prev_r;

  // ****************************************
  // Event flags
  // ****************************************
  // Cascade sets only channel 1 flags; set beats clear
  always @* begin
    events_nxt = events_r;
    if (wr_events) begin
      events_nxt = events_r & ~w_data_r[3:0];
    end
    events_nxt[`BIT_EV_UF0] = events_nxt[`BIT_EV_UF0] |
                              (uf0_ev & ~width_select_r);
    events_nxt[`BIT_EV_CM0] = events_nxt[`BIT_EV_CM0] |
                              (cm0_ev & ~width_select_r);
    events_nxt[`BIT_EV_UF1] = events_nxt[`BIT_EV_UF1] | uf1_ev;
    events_nxt[`BIT_EV_CM1] = events_nxt[`BIT_EV_CM1] | cm1_ev;
  end
  // Flag storage
  always @(posedge clock) begin
    if (!rst_n) begin
      events_r <= 4'h0;
    end else begin
      events_r <= events_nxt;
    end
  end

  // ****************************************
  // Timer output waveform
  // ****************************************
  // Underflow is a one-cycle pulse; its falling edge is one clock later
  always @(posedge clock) begin
    if (!rst_n) begin
      uf_seen_r <= 2'h0;
    end else begin
      uf_seen_r <= {uf1_ev, uf0_ev & ~width_select_r};
    end
  end
  assign uf_pulse = uf_seen_r;
  assign cm_pulse = {eq1_prev_r & ~eq1, eq0_prev_r & ~eq0};
  // Reload not above compare keeps the wave high
  assign fixed_high[0] = (ch0_reload_value_r <= ch0_compare_value_r);
  assign fixed_high[1] = width_select_r ?
                         ({ch1_reload_value_r, ch0_reload_value_r} <=
                          {ch1_compare_value_r, ch0_compare_value_r}) :
                         (ch1_reload_value_r <= ch1_compare_value_r);
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_wave
      // Rise after underflow, fall after compare match
      always @(posedge clock) begin
        if (!rst_n) begin
          wave_r[gi] <= 1'b0;
        end else if (uf_pulse[gi]) begin
          wave_r[gi] <= 1'b1;
        end else if (cm_pulse[gi]) begin
          wave_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Output enables gate; channel 0 off in cascade
  always @(posedge clock) begin
    if (!rst_n) begin
      timer_wave_out <= 2'h0;
    end else begin
      timer_wave_out[0] <= ch0_output_enable_r & ~width_select_r &
                           (wave_r[0] | fixed_high[0]);
      timer_wave_out[1] <= ch1_output_enable_r &
                           (wave_r[1] | fixed_high[1]);
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign s_axi_arready = ~s_axi_rvalid;

  // Counter buffers read the live count without side effects
  always @* begin
    rdata_nxt = 32'h0000_0000;
    rhit_nxt = 1'b1;
    if (is_reg(s_axi_araddr, `IDX_CTRL0)) begin
      rdata_nxt[`BIT_WIDTH_SEL] = width_select_r;
      rdata_nxt[`BIT_OUT_EN] = ch0_output_enable_r;
      rdata_nxt[`BIT_RUN] = ch0_run_r;
      rdata_nxt[`BIT_CLK_SRC] = ch0_clock_source_r;
    end else if (is_reg(s_axi_araddr, `IDX_CTRL1)) begin
      rdata_nxt[`BIT_OUT_EN] = ch1_output_enable_r;
      rdata_nxt[`BIT_RUN] = ch1_run_r;
      rdata_nxt[`BIT_CLK_SRC] = ch1_clock_source_r;
    end else if (is_reg(s_axi_araddr, `IDX_RELOAD0)) begin
      rdata_nxt[7:0] = ch0_reload_value_r;
    end else if (is_reg(s_axi_araddr, `IDX_RELOAD1)) begin
      rdata_nxt[7:0] = ch1_reload_value_r;
    end else if (is_reg(s_axi_araddr, `IDX_COMPARE0)) begin
      rdata_nxt[7:0] = ch0_compare_value_r;
    end else if (is_reg(s_axi_araddr, `IDX_COMPARE1)) begin
      rdata_nxt[7:0] = ch1_compare_value_r;
    end else if (is_reg(s_axi_araddr, `IDX_COUNT0)) begin
      rdata_nxt[7:0] = cnt0_r;
    end else if (is_reg(s_axi_araddr, `IDX_COUNT1)) begin
      rdata_nxt[7:0] = cnt1_r;
    end else if (is_reg(s_axi_araddr, `IDX_EVENTS)) begin
      rdata_nxt[3:0] = events_r;
    end else begin
      rhit_nxt = 1'b0;
    end
  end

  // Read data is captured when the address is taken
  always @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rhit_nxt ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== tb/timer_checker_sva.sv ====
`timescale 1ns/1ps
module timer_checker (
  input wire clock,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] timer_wave_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ****
  // Bus answers
  // ****
  // Write answer held until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped early");
  // No new write taken while answer pending
  property p_aw_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse)
    else $error("write taken during pending answer");
  property p_ar_ready;
    s_axi_arready != s_axi_rvalid;
  endproperty
  a_ar_ready: assert property (p_ar_ready)
    else $error("read ready not inverse of rvalid");
  // Fixed answer delays of the slave
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer)
    else $error("write answer late");
  // Registers are one byte wide; error reads carry zero
  property p_r_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000
      && (s_axi_rresp != 2'h2 || s_axi_rdata == 32'h00000000);
  endproperty
  a_r_upper: assert property (p_r_upper)
    else $error("read data upper bits set");
  // Output enables clear at reset, so no waveform
  property p_wave_rst;
    $rose(rst_n) |-> timer_wave_out == 2'h0;
  endproperty
  a_wave_rst: assert property (p_wave_rst)
    else $error("waveform active out of reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_wave: cover property ($rose(timer_wave_out[0]));
endmodule

// ==== tb/test_dual_mode_reload_down_timer.sv ====
`timescale 1ns/1ps
`include "timer_consts.vh"
`define CHK(g, e) begin tests_run = tests_run + 1; \
  if ((g) !== (e)) begin err_total = err_total + 1; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module test_dual_mode_reload_down_timer;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [19:0] s_axi_awaddr = 20'h00000;
  reg [19:0] s_axi_araddr = 20'h00000;
  reg [31:0] s_axi_wdata = 32'h00000000;
  reg s_axi_awvalid = 1'b0;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  reg [3:0] src = 4'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, timer_wave_out;
  wire [31:0] s_axi_rdata;
  integer err_total = 0;
  integer tests_run = 0;
  reg [7:0] d;
  reg [1:0] r;
  // Source bits: ch0 pre, ch1 pre, ch0 event, ch1 event
  dual_mode_reload_down_timer dual_mode_reload_down_timer_i (
    .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ch0_prescaler_clock(src[0]),
    .ch1_prescaler_clock(src[1]), .ch0_event_clock(src[2]),
    .ch1_event_clock(src[3]), .timer_wave_out
  );
  always #12.5 clock = ~clock;
  // ****
  // Bus tasks
  // ****
  // Channels released one by one as each is taken
  task w(input [17:0] idx, input [7:0] v);
    reg aw_done;
    reg w_done;
    begin
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h000000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!aw_done || !w_done) begin
        @(posedge clock);
        if (!aw_done && s_axi_awready === 1'b1) begin
          aw_done = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (!w_done && s_axi_wready === 1'b1) begin
          w_done = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      s_axi_bready <= 1'b1;
      @(posedge clock);
      while (s_axi_bvalid !== 1'b1) @(posedge clock);
      `CHK(s_axi_bresp, `RESP_OKAY)
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [17:0] idx);
    begin
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      @(posedge clock);
      while (s_axi_arready !== 1'b1) @(posedge clock);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      @(posedge clock);
      while (s_axi_rvalid !== 1'b1) @(posedge clock);
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task rc(input [17:0] idx, input [7:0] e);
    begin
      rd(idx);
      `CHK(d, e)
    end
  endtask
  // Each pulse spans two cycles high and two low
  task pulse(input [3:0] m, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        src <= m;
        repeat (2) @(posedge clock);
        src <= 4'h0;
        repeat (2) @(posedge clock);
      end
      repeat (2) @(posedge clock);
    end
  endtask
  // ****
  // Scenarios
  // ****
  task t_reset;
    begin
      rc(`IDX_RELOAD0, 8'hFF);
      rc(`IDX_RELOAD1, 8'hFF);
      rc(`IDX_COMPARE0, 8'h00);
      rc(`IDX_COMPARE1, 8'h00);
      rc(`IDX_CTRL0, 8'h00);
      rd(`IDX_EVENTS + 18'h00001);
      `CHK(r, `RESP_SLVERR)
    end
  endtask
  task t_run;
    begin
      w(`IDX_RELOAD0, 8'h03);
      // Preset before the run bit is set
      w(`IDX_CTRL0, 8'h02);
      rc(`IDX_CTRL0, 8'h00);
      rc(`IDX_COUNT0, 8'h03);
      w(`IDX_CTRL0, 8'h04);
      pulse(4'h1, 2);
      rc(`IDX_COUNT0, 8'h01);
      w(`IDX_CTRL0, 8'h00);
      pulse(4'h1, 2);
      rc(`IDX_COUNT0, 8'h01);
      w(`IDX_CTRL0, 8'h04);
      pulse(4'h4, 1);
      rc(`IDX_COUNT0, 8'h01);
      pulse(4'h1, 2);
      rc(`IDX_COUNT0, 8'h03);
      rc(`IDX_EVENTS, 8'h03);
      pulse(4'h1, 1);
      rc(`IDX_COUNT0, 8'h02);
      w(`IDX_EVENTS, 8'h0F);
      rc(`IDX_EVENTS, 8'h00);
    end
  endtask
  task t_ext;
    begin
      w(`IDX_RELOAD1, 8'h10);
      w(`IDX_CTRL1, 8'h02);
      w(`IDX_CTRL1, 8'h05);
      pulse(4'h2, 1);
      rc(`IDX_COUNT1, 8'h10);
      pulse(4'h8, 3);
      rc(`IDX_COUNT1, 8'h0D);
      w(`IDX_CTRL1, 8'h00);
    end
  endtask
  // Reload not above compare keeps the wave high
  task t_wave;
    begin
      w(`IDX_CTRL0, 8'h00);
      w(`IDX_COMPARE0, 8'h03);
      w(`IDX_CTRL0, 8'h08);
      repeat (4) @(posedge clock);
      `CHK(timer_wave_out[0], 1'b1)
      w(`IDX_CTRL0, 8'h00);
      repeat (4) @(posedge clock);
      `CHK(timer_wave_out[0], 1'b0)
      w(`IDX_RELOAD0, 8'h04);
      w(`IDX_COMPARE0, 8'h01);
      w(`IDX_CTRL0, 8'h0E);
      pulse(4'h1, 5);
      repeat (2) @(posedge clock);
      `CHK(timer_wave_out[0], 1'b1)
      pulse(4'h1, 4);
      repeat (2) @(posedge clock);
      `CHK(timer_wave_out[0], 1'b0)
      w(`IDX_CTRL0, 8'h00);
      w(`IDX_COMPARE0, 8'h00);
      w(`IDX_EVENTS, 8'h0F);
    end
  endtask
  task t_cascade;
    begin
      w(`IDX_RELOAD0, 8'h02);
      w(`IDX_RELOAD1, 8'h01);
      w(`IDX_CTRL0, 8'h80);
      w(`IDX_CTRL1, 8'h0F);
      rc(`IDX_COUNT1, 8'h0D);
      w(`IDX_CTRL0, 8'h8A);
      rc(`IDX_COUNT0, 8'h02);
      rc(`IDX_COUNT1, 8'h01);
      w(`IDX_CTRL0, 8'h8C);
      pulse(4'hA, 2);
      rc(`IDX_COUNT1, 8'h01);
      pulse(4'h1, 3);
      rc(`IDX_COUNT0, 8'hFF);
      rc(`IDX_COUNT1, 8'h00);
      `CHK(timer_wave_out[0], 1'b0)
      `CHK(timer_wave_out[1], 1'b0)
      pulse(4'h1, 256);
      rc(`IDX_COUNT0, 8'h02);
      rc(`IDX_COUNT1, 8'h01);
      rc(`IDX_EVENTS, 8'h0C);
      `CHK(timer_wave_out[1], 1'b1)
      w(`IDX_CTRL0, 8'h80);
      pulse(4'h1, 2);
      rc(`IDX_COUNT0, 8'h02);
    end
  endtask
  task stop_test;
    begin
      if (err_total == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset;
    t_run;
    t_ext;
    t_wave;
    t_cascade;
    stop_test;
  end
  // Watchdog well above the expected run length
  initial begin
    repeat (30000) @(posedge clock);
    err_total = err_total + 1;
    stop_test;
  end
endmodule
bind dual_mode_reload_down_timer timer_checker timer_checker_i (
  .clock, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .timer_wave_out
);
